// ---- mscm_pkg.sv ----
// Purpose: Shared constants for the Manchester sync and clock measure block
// Assumes: Registers sit at their printed offsets on a 16-bit plain port
// Notes:   Every offset, nonzero reset value, window and error count, and field position but status bits 2:0 lives here
package mscm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] CTRL_OFS     = 8'h11;
  localparam logic [7:0] COUNT_OFS    = 8'h12;
  localparam logic [7:0] STAT_OFS     = 8'h13;
  localparam logic [7:0] CFG_OFS      = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h15;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h16;

  localparam int CTRL_BUF32_EN_BIT = 13;
  localparam int CTRL_BUF54_EN_BIT = 14;
  localparam int CTRL_CORE_SEL_BIT = 15;
  localparam int STAT_SEL_LO       = 4;
  localparam int STAT_RSVD_BIT     = 3;
  localparam int CFG_CORE_EN_BIT   = 0;

  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET  = 16'h0030;
  localparam logic [1:0]  SEL_DISABLE = 2'h3;
  localparam logic [1:0]  SEL_RESET   = STAT_RESET[5:4];

  localparam logic CORE_SUP = 1'b0;
  localparam logic CORE_DSP = 1'b1;

  // Window is 2^9 periods of the 32kHz reference
  localparam int REF_WINDOW_LOG2 = 9;
  localparam int REF_WINDOW      = 1 << REF_WINDOW_LOG2;

  localparam int ERR_LIMIT    = 3;
  localparam int FRAME_WINDOW = 10;

  localparam int IRQ_W        = 8;
  localparam int IRQ_BUF_LO   = 0;
  localparam int IRQ_DONE_BIT = 4;
  localparam int IRQ_LOSS_LO  = 5;

  typedef enum logic {MS_IDLE, MS_RUN} mscm_meas_t;
endpackage

// ---- mscm_sync_mon.sv ----
// Purpose: Sync status and loss-of-sync watch for one Manchester decoder
// Assumes: Pulses come from decoder logic on sys_clk
// Notes:   Loss wins over a sync bit in the same cycle
`timescale 1ns/100ps
module mscm_sync_mon
  import mscm_pkg::*;
#(
  parameter int ERR_LIM = mscm_pkg::ERR_LIMIT,
  parameter int FRAMES  = mscm_pkg::FRAME_WINDOW
)
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic syncBitPulse,
  input  wire logic syncErrPulse,
  input  wire logic frameTick,
  output logic      synced_q,
  output logic      lossPulse_q
);
  localparam int EW = $clog2(ERR_LIM + 1);
  localparam int FW = $clog2(FRAMES + 1);
  localparam logic [EW-1:0] ERR_LAST = EW'(ERR_LIM - 1);
  localparam logic [FW-1:0] FRM_LAST = FW'(FRAMES - 1);

  logic [EW-1:0] errCnt_q;
  logic [EW-1:0] errCnt_d;
  logic [FW-1:0] frameCnt_q;
  logic [FW-1:0] frameCnt_d;
  logic          synced_d;
  wire           windowOpen = (errCnt_q != '0);
  wire           errHit     = synced_q && syncErrPulse;
  wire           lose       = errHit && (errCnt_q == ERR_LAST);
  wire           expire     = windowOpen && frameTick
                              && (frameCnt_q == FRM_LAST);

  // Counter idles after a quiet window and restarts on the next error
  assign errCnt_d = (!synced_q || lose) ? '0 :          // see [RULE11]
                    errHit ? errCnt_q + 1'b1 :
                    expire ? '0 : errCnt_q;
  assign frameCnt_d = (errHit && !windowOpen) ? '0 :
                      (windowOpen && frameTick) ? frameCnt_q + 1'b1 :
                      frameCnt_q;
  assign synced_d = lose ? 1'b0 :                        // see [RULE11]
                    syncBitPulse ? 1'b1 : synced_q;      // see [RULE10]

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      errCnt_q    <= '0;
      frameCnt_q  <= '0;
      synced_q    <= 1'b0;
      lossPulse_q <= 1'b0;
    end
    else
    begin
      errCnt_q    <= errCnt_d;
      frameCnt_q  <= frameCnt_d;
      synced_q    <= synced_d;
      lossPulse_q <= lose;
    end
  end

  a_loss_clears: assert property (              // see [RULE11]
    @(posedge sys_clk) disable iff (!arst_n)
    lossPulse_q |-> !synced_q && $past(synced_q))
    else $error("sync kept after loss");

  a_sync_cause: assert property (               // see [RULE10]
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(synced_q) |-> $past(syncBitPulse))
    else $error("sync set without sync bit");

  a_third_error: assert property (              // see [RULE11]
    @(posedge sys_clk) disable iff (!arst_n)
    errHit && errCnt_q == ERR_LAST |=> lossPulse_q && !synced_q)
    else $error("third error did not drop sync");
endmodule

// ---- mscm_top.sv ----
// Purpose: Converter irq routing, clock correction count, decoder status
// Assumes: One register port shared by both cores, busCore names the core
// Notes:   ref32kPin is asynchronous; all decoder pulses are on sys_clk
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] Control bit 13 enables buffer-full interrupts of buffers 3 and 2.
// [RULE2] Control bit 14 enables buffer-full interrupts of buffers 5 and 4.
// [RULE3] Core-select 0 routes interrupts and clearing to supervisory core.
// [RULE4] Only the supervisory core may write the core-select bit.
// [RULE5] Count register resets to 0000h, readable by both cores.
// [RULE6] Count sync bits of selected decoder over 512 reference periods.
// [RULE7] Writing a select value other than 11b starts one measurement.
// [RULE8] Count reads 0000h while busy, then holds the final count.
// [RULE9] Status resets to 30h; software writes reach only bits 5:4.
// [RULE10] Per-decoder sync bit reads 1 once synchronized, else 0.
// [RULE11] Three sync errors within 10 frames drop sync; counter restarts.
// [RULE12] Status bit 3 is reserved and reads zero.
// [RULE13] Select 11b disables measuring; 00b,01b,10b pick decoders 0-2.
// [RULE14] Each core owns a select copy; core-enable picks the active one.
// [RULE15] Software polls for nonzero count and avoids cross-core requests.
module mscm_top
  import mscm_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic                        busCore,
  input  wire logic [mscm_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [mscm_pkg::DATA_W-1:0] regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [mscm_pkg::DATA_W-1:0] regRdata_q,
  input  wire logic [3:0]                  bufFullEvt,
  input  wire logic                        ref32kPin,
  input  wire logic [2:0]                  syncBitPulse,
  input  wire logic [2:0]                  syncErrPulse,
  input  wire logic [2:0]                  frameTick,
  output logic                             irqSupervisory_q,
  output logic                             irqSignalProc_q,
  output logic      [2:0]                  decoderSynced
);
  localparam int RW = REF_WINDOW_LOG2;
  localparam logic [RW-1:0] REF_LAST = RW'(REF_WINDOW - 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Register port decode
  wire ctrlWr    = regWr && hit(regAddr, CTRL_OFS);
  wire statWr    = regWr && hit(regAddr, STAT_OFS);
  wire cfgWr     = regWr && hit(regAddr, CFG_OFS);
  wire maskWr    = regWr && hit(regAddr, IRQ_MASK_OFS);
  wire irqStatRd = regRd && hit(regAddr, IRQ_STAT_OFS);

  // Converter control
  logic buf32En_q;
  logic buf54En_q;
  logic coreSel_q;
  logic coreSel_d;
  assign coreSel_d = (ctrlWr && busCore == CORE_SUP) ?    // see [RULE4]
                     regWdata[CTRL_CORE_SEL_BIT] : coreSel_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf32En_q <= 1'b0;
      buf54En_q <= 1'b0;
      coreSel_q <= CORE_SUP;
    end
    else
    begin
      if (ctrlWr)
      begin
        buf32En_q <= regWdata[CTRL_BUF32_EN_BIT];
        buf54En_q <= regWdata[CTRL_BUF54_EN_BIT];
      end
      coreSel_q <= coreSel_d;
    end
  end

  // Per-core select copies and the core-enable bit
  logic [1:0] selSup_q;
  logic [1:0] selDsp_q;
  logic       coreEn_q;
  wire  [1:0] newSel   = regWdata[STAT_SEL_LO +: 2];
  wire        activeWr = statWr && (busCore == coreEn_q); // see [RULE14]
  wire        startReq = activeWr && newSel != SEL_DISABLE; // see [RULE7]
  wire        stopReq  = activeWr && newSel == SEL_DISABLE; // see [RULE13]

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      selSup_q <= SEL_RESET;
      selDsp_q <= SEL_RESET;
      coreEn_q <= CORE_SUP;
    end
    else
    begin
      if (statWr && busCore == CORE_SUP)
        selSup_q <= newSel;                             // see [RULE9]
      if (statWr && busCore == CORE_DSP)
        selDsp_q <= newSel;                             // see [RULE9]
      if (cfgWr)
        coreEn_q <= regWdata[CFG_CORE_EN_BIT];
    end
  end

  // Reference pin: three stages, change taken once stages two and three agree
  logic refMeta_q;
  logic refS2_q;
  logic refS3_q;
  logic refLevel_q;
  wire  refStable = (refS2_q == refS3_q);
  wire  refRise   = refStable && refS3_q && !refLevel_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      refMeta_q  <= 1'b0;
      refS2_q    <= 1'b0;
      refS3_q    <= 1'b0;
      refLevel_q <= 1'b0;
    end
    else
    begin
      refMeta_q <= ref32kPin;
      refS2_q   <= refMeta_q;
      refS3_q   <= refS2_q;
      if (refStable)
        refLevel_q <= refS3_q;
    end
  end

  // Measurement engine
  mscm_meas_t    measState_q;
  mscm_meas_t    measState_d;
  logic [1:0]    measDec_q;
  logic [RW-1:0] refCnt_q;
  logic [15:0]   syncCnt_q;
  logic [15:0]   count_q;
  logic [15:0]   count_d;
  logic          measDone;

  wire running  = (measState_q == MS_RUN);
  wire decHit   = syncBitPulse[measDec_q];
  wire cntFull  = (syncCnt_q == 16'hFFFF);
  // Saturate rather than wrap, a wrapped count would look plausible
  wire [15:0] syncNext = (decHit && !cntFull) ?
                         syncCnt_q + 16'h0001 : syncCnt_q;
  wire windowEnd = running && refRise && (refCnt_q == REF_LAST); // see [RULE6]

  always_comb
  begin
    measState_d = measState_q;
    measDone    = 1'b0;
    case (measState_q)
      MS_IDLE:
      begin
        if (startReq)
          measState_d = MS_RUN;
      end
      MS_RUN:
      begin
        if (stopReq)
          measState_d = MS_IDLE;
        else if (startReq)
          measState_d = MS_RUN;
        else if (windowEnd)
        begin
          measState_d = MS_IDLE;
          measDone    = 1'b1;
        end
      end
      default:
        measState_d = MS_IDLE;
    endcase
  end

  assign count_d = startReq ? COUNT_RESET :              // see [RULE8]
                   measDone ? syncNext : count_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      measState_q <= MS_IDLE;
      measDec_q   <= 2'h0;
      refCnt_q    <= '0;
      syncCnt_q   <= 16'h0000;
      count_q     <= COUNT_RESET;                        // see [RULE5]
    end
    else
    begin
      measState_q <= measState_d;
      count_q     <= count_d;
      if (startReq)
      begin
        measDec_q <= newSel;                             // see [RULE13]
        refCnt_q  <= '0;
        syncCnt_q <= 16'h0000;
      end
      else if (running)
      begin
        syncCnt_q <= syncNext;                           // see [RULE6]
        if (refRise)
          refCnt_q <= refCnt_q + 1'b1;
      end
    end
  end

  // Decoder sync monitors
  logic [2:0] lossPulse;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_dec
      mscm_sync_mon u_mon (
        .sys_clk      (sys_clk),
        .arst_n       (arst_n),
        .syncBitPulse (syncBitPulse[gi]),
        .syncErrPulse (syncErrPulse[gi]),
        .frameTick    (frameTick[gi]),
        .synced_q     (decoderSynced[gi]),
        .lossPulse_q  (lossPulse[gi])
      );
    end
  endgenerate

  // Interrupt status, mask and routing
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqMask_q;
  wire  [IRQ_W-1:0] irqEvt   = {lossPulse, measDone, bufFullEvt};
  // Only the routed core may clear; the other core reads without side effect
  wire              ownerRd  = irqStatRd
                               && (busCore == coreSel_q);   // see [RULE3]
  // Set wins over a clear in the same cycle
  wire  [IRQ_W-1:0] irqStat_d = (ownerRd ? '0 : irqStat_q) | irqEvt;
  wire  [IRQ_W-1:0] localEn  = {4'hF, buf54En_q, buf54En_q,  // see [RULE2]
                                buf32En_q, buf32En_q};       // see [RULE1]
  wire              irqAny   = |(irqStat_q & irqMask_q & localEn);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat_q        <= '0;
      irqMask_q        <= '0;
      irqSupervisory_q <= 1'b0;
      irqSignalProc_q  <= 1'b0;
    end
    else
    begin
      irqStat_q        <= irqStat_d;
      if (maskWr)
        irqMask_q <= regWdata[IRQ_W-1:0];
      irqSupervisory_q <= irqAny && coreSel_q == CORE_SUP; // see [RULE3]
      irqSignalProc_q  <= irqAny && coreSel_q == CORE_DSP; // see [RULE3]
    end
  end

  // Read path, data valid only in the cycle after the strobe
  wire [1:0]  readerSel = (busCore == CORE_DSP) ? selDsp_q : selSup_q;
  wire [15:0] statView  = {10'h000, readerSel, 1'b0,     // see [RULE12]
                           decoderSynced};               // see [RULE10]
  wire [15:0] ctrlView  = {coreSel_q, buf54En_q, buf32En_q, 13'h0000};
  wire [15:0] rdMux =
    hit(regAddr, CTRL_OFS)     ? ctrlView :
    hit(regAddr, COUNT_OFS)    ? count_q :               // see [RULE5]
    hit(regAddr, STAT_OFS)     ? statView :
    hit(regAddr, CFG_OFS)      ? {15'h0000, coreEn_q} :
    hit(regAddr, IRQ_STAT_OFS) ? {8'h00, irqStat_q} :
    hit(regAddr, IRQ_MASK_OFS) ? {8'h00, irqMask_q} : 16'h0000;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata_q <= 16'h0000;
    else
      regRdata_q <= regRd ? rdMux : 16'h0000;
  end

  // Checks
  a_busy_zero: assert property (                         // see [RULE8]
    @(posedge sys_clk) disable iff (!arst_n)
    running && !$rose(running) |-> count_q == 16'h0000)
    else $error("count nonzero while busy");

  a_start_meas: assert property (                        // see [RULE7]
    @(posedge sys_clk) disable iff (!arst_n)
    startReq |=> running && count_q == 16'h0000 && measDec_q == $past(newSel))
    else $error("select write did not start");

  a_disable_sel: assert property (                       // see [RULE13]
    @(posedge sys_clk) disable iff (!arst_n)
    stopReq |=> !running)
    else $error("select 11b did not stop");

  a_core_sel_wr: assert property (                       // see [RULE4]
    @(posedge sys_clk) disable iff (!arst_n)
    ctrlWr && busCore == CORE_DSP |=> $stable(coreSel_q))
    else $error("second core changed core select");

  a_irq_route: assert property (                         // see [RULE3]
    @(posedge sys_clk) disable iff (!arst_n)
    !(irqSupervisory_q && irqSignalProc_q)
    and (irqSignalProc_q |-> $past(coreSel_q) == CORE_DSP))
    else $error("interrupt sent to wrong core");

  a_clear_owner: assert property (                       // see [RULE3]
    @(posedge sys_clk) disable iff (!arst_n)
    irqStatRd && busCore != coreSel_q |=> irqStat_q == $past(irqStat_d)
    && (irqStat_q & $past(irqStat_q)) == $past(irqStat_q))
    else $error("non-owner read cleared flags");

  a_rsvd_zero: assert property (                         // see [RULE12]
    @(posedge sys_clk) disable iff (!arst_n)
    regRd && hit(regAddr, STAT_OFS) |=> !regRdata_q[STAT_RSVD_BIT]
    && regRdata_q[2:0] == $past(decoderSynced))
    else $error("status bit 3 read nonzero");

  a_window_len: assert property (                        // see [RULE6]
    @(posedge sys_clk) disable iff (!arst_n)
    measDone |-> refRise && refCnt_q == REF_LAST)
    else $error("window not 512 reference periods");

  a_done_load: assert property (                         // see [RULE8]
    @(posedge sys_clk) disable iff (!arst_n)
    measDone |=> count_q == $past(syncNext) && !running)
    else $error("final count not loaded");

  a_buf_enable: assert property (                        // see [RULE1]
    @(posedge sys_clk) disable iff (!arst_n)
    irqStat_q[IRQ_W-1:2] == '0 && !buf32En_q
    |=> !irqSupervisory_q && !irqSignalProc_q)
    else $error("buffer 3:2 irq with enable off");

  a_buf54_enable: assert property (                      // see [RULE2]
    @(posedge sys_clk) disable iff (!arst_n)
    irqStat_q[1:0] == 2'h0 && irqStat_q[IRQ_W-1:4] == '0 && !buf54En_q
    |=> !irqSupervisory_q && !irqSignalProc_q)
    else $error("buffer 5:4 irq with enable off");

  a_copy_pick: assert property (                         // see [RULE14]
    @(posedge sys_clk) disable iff (!arst_n)
    statWr && busCore != coreEn_q && !windowEnd |=> $stable(measState_q)
    && $stable(measDec_q))
    else $error("inactive copy drove measurement");
endmodule

// ---- mscm_modulator_model.sv ----
// Purpose: Stand-in for three delta-sigma modulators and their decoders
// Assumes: Decoded sync results reach the block as one-cycle sys_clk pulses
// Notes:   Frame lengths differ per channel so measured counts differ
`timescale 1ns/100ps
module mscm_modulator_model
#(
  parameter int FRAME0 = 6,
  parameter int FRAME1 = 8,
  parameter int FRAME2 = 10
)
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] bitEn,
  input  wire logic [2:0] errEn,
  output logic      [2:0] syncBitPulse,
  output logic      [2:0] syncErrPulse,
  output logic      [2:0] frameTick
);
  localparam int FRAME_LEN [3] = '{FRAME0, FRAME1, FRAME2};
  logic [7:0] cnt_q [3];

  // A silent channel still frames; it just lacks the alternating sync bit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!arst_n)
      begin
        cnt_q[i]        <= 8'h00;
        frameTick[i]    <= 1'b0;
        syncBitPulse[i] <= 1'b0;
        syncErrPulse[i] <= 1'b0;
      end
      else
      begin
        cnt_q[i]        <= (cnt_q[i] == 8'(FRAME_LEN[i] - 1)) ?
                           8'h00 : cnt_q[i] + 8'h01;
        frameTick[i]    <= (cnt_q[i] == 8'(FRAME_LEN[i] - 1));
        syncBitPulse[i] <= (cnt_q[i] == 8'(FRAME_LEN[i] - 1)) &&
                           bitEn[i] && !errEn[i];
        syncErrPulse[i] <= (cnt_q[i] == 8'(FRAME_LEN[i] - 1)) && errEn[i];
      end
    end
  end
endmodule

// ---- manchester_sync_clock_measure_test.sv ----
// Purpose: Register-level test of sync status, irq routing and clock count
// Assumes: Reference toggles every 4 sys_clk cycles to keep windows short
// Notes:   Counts are checked within a band set by reference phase
`timescale 1ns/100ps
module manchester_sync_clock_measure_test;
  import mscm_pkg::*;
  localparam int REF_HALF  = 4;
  localparam int WIN       = REF_WINDOW * REF_HALF * 2;
  localparam int FRAME [3] = '{6, 8, 10};

  logic              sys_clk;
  logic              arst_n;
  logic              busCore;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata_q;
  logic [3:0]        bufFullEvt;
  logic              ref32kPin;
  logic [2:0]        syncBitPulse;
  logic [2:0]        syncErrPulse;
  logic [2:0]        frameTick;
  logic [2:0]        bitEn;
  logic [2:0]        errEn;
  logic [2:0]        decoderSynced;
  logic              irqSupervisory_q;
  logic              irqSignalProc_q;
  logic [15:0]       d;
  int                errTotal;
  int                nTests;

  mscm_top mscm_top_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .busCore(busCore), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
    .bufFullEvt(bufFullEvt), .ref32kPin(ref32kPin),
    .syncBitPulse(syncBitPulse), .syncErrPulse(syncErrPulse),
    .frameTick(frameTick), .irqSupervisory_q(irqSupervisory_q),
    .irqSignalProc_q(irqSignalProc_q), .decoderSynced(decoderSynced));

  mscm_modulator_model mscm_modulator_model_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .bitEn(bitEn), .errEn(errEn),
    .syncBitPulse(syncBitPulse), .syncErrPulse(syncErrPulse),
    .frameTick(frameTick));

  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic timeOut(input string what);
    errTotal++;
    $display("MISMATCH %s expected completion seen timeout", what);
    wrapUp();
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    nTests++;
    if (got !== exp)
    begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One reference period of slack covers the reference phase at start
  task automatic chkRange(input string what, input int f,
                          input logic [15:0] got);
    int lo;
    int hi;
    lo = (WIN - 2 * REF_HALF) / f - 1;
    hi = (WIN + 2 * REF_HALF) / f + 1;
    nTests++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      errTotal++;
      $display("MISMATCH %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask

  task automatic regWrite(input logic c, input logic [7:0] a,
                          input logic [15:0] v);
    @(posedge sys_clk);
    busCore  <= c;
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic regRead(input logic c, input logic [7:0] a,
                         output logic [15:0] v);
    @(posedge sys_clk);
    busCore <= c;
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    v = regRdata_q;
  endtask

  task automatic rdChk(input logic c, input logic [7:0] a,
                       input logic [15:0] exp, input string what);
    logic [15:0] v;
    regRead(c, a, v);
    chk(what, exp, v);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Returns just after a tick, so a change made next lands before a frame
  task automatic waitFrames(input int n, input int ch);
    int k = 0;
    repeat (n * 40)
    begin
      @(posedge sys_clk);
      if (frameTick[ch] === 1'b1)
        k++;
      if (k == n)
        return;
    end
    timeOut("frameTick");
  endtask

  task automatic pulseEvt(input logic [3:0] e);
    @(posedge sys_clk);
    bufFullEvt <= e;
    @(posedge sys_clk);
    bufFullEvt <= 4'h0;
  endtask

  task automatic pollCount(input logic c, output logic [15:0] v);
    repeat (3000)
    begin
      regRead(c, COUNT_OFS, v);
      if (v !== 16'h0000)
        return;
    end
    timeOut("count");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Phase offset keeps the reference unrelated to sys_clk edges
  initial
  begin
    ref32kPin = 1'b0;
    #3;
    forever #(REF_HALF * 10) ref32kPin = ~ref32kPin;
  end

  initial
  begin
    #1ms;
    timeOut("run");
  end

  initial
  begin
    arst_n     = 1'b0;
    busCore    = 1'b0;
    regAddr    = 8'h00;
    regWdata   = 16'h0000;
    regWr      = 1'b0;
    regRd      = 1'b0;
    bufFullEvt = 4'h0;
    bitEn      = 3'h0;
    errEn      = 3'h0;
    errTotal   = 0;
    nTests     = 0;
    cycles(6);
    arst_n <= 1'b1;
    chk("synced reset", 16'h0000, 16'(decoderSynced));
    rdChk(0, COUNT_OFS, 16'h0000, "count reset");
    rdChk(1, COUNT_OFS, 16'h0000, "count core1");
    rdChk(0, STAT_OFS, 16'h0030, "status reset");
    rdChk(0, CTRL_OFS, 16'h0000, "ctrl reset");
    regWrite(0, 8'h20, 16'hFFFF);
    rdChk(0, 8'h20, 16'h0000, "unmapped");
    regWrite(0, STAT_OFS, 16'hFFFF);
    rdChk(0, STAT_OFS, 16'h0030, "status write");
    bitEn <= 3'h7;
    waitFrames(2, 2);
    cycles(2);
    chk("synced", 16'h0007, 16'(decoderSynced));
    rdChk(0, STAT_OFS, 16'h0037, "status synced");
    waitFrames(1, 1);
    errEn <= 3'h2;
    waitFrames(2, 1);
    errEn <= 3'h0;
    cycles(2);
    chk("two errors", 16'h0007, 16'(decoderSynced));
    waitFrames(12, 1);
    errEn <= 3'h2;
    waitFrames(3, 1);
    cycles(3);
    chk("sync lost", 16'h0005, 16'(decoderSynced));
    rdChk(0, STAT_OFS, 16'h0035, "status lost");
    rdChk(0, IRQ_STAT_OFS, 16'h0040, "loss event");
    errEn <= 3'h0;
    waitFrames(2, 1);
    cycles(2);
    chk("resynced", 16'h0007, 16'(decoderSynced));
    regWrite(0, IRQ_MASK_OFS, 16'h000F);
    rdChk(0, IRQ_MASK_OFS, 16'h000F, "mask");
    for (int k = 0; k < 2; k++)
    begin
      regWrite(0, CTRL_OFS, 16'h4000 >> k);
      pulseEvt(k ? 4'hC : 4'h3);
      cycles(3);
      chk("irq gated", 16'h0000,
          16'(irqSupervisory_q));
      regWrite(0, CTRL_OFS, 16'h2000 << k);
      cycles(3);
      chk("irq on", 16'h0001,
          16'(irqSupervisory_q));
      rdChk(0, IRQ_STAT_OFS, k ? 16'h000C : 16'h0003,
            "buf evt");
      cycles(2);
      chk("irq off", 16'h0000, 16'(irqSupervisory_q));
      rdChk(0, IRQ_STAT_OFS, 16'h0000, "cleared");
    end
    regWrite(1, CTRL_OFS, 16'hA000);
    rdChk(1, CTRL_OFS, 16'h2000, "core1 select");
    regWrite(0, CTRL_OFS, 16'hA000);
    rdChk(1, CTRL_OFS, 16'hA000, "core0 select");
    pulseEvt(4'h2);
    cycles(3);
    chk("route dsp", 16'h0002,
        16'({irqSignalProc_q, irqSupervisory_q}));
    rdChk(0, IRQ_STAT_OFS, 16'h0002, "no clear core0");
    rdChk(1, IRQ_STAT_OFS, 16'h0002, "clear core1");
    rdChk(1, IRQ_STAT_OFS, 16'h0000, "cleared core1");
    chk("route off", 16'h0000,
        16'({irqSignalProc_q, irqSupervisory_q}));
    regWrite(1, CTRL_OFS, 16'h0000);
    rdChk(0, CTRL_OFS, 16'h8000, "select kept");
    regWrite(0, CTRL_OFS, 16'h0000);
    regWrite(0, IRQ_MASK_OFS, 16'h0010);
    for (int i = 0; i < 3; i++)
    begin
      regWrite(0, STAT_OFS, 16'(i << 4));
      rdChk(1, COUNT_OFS, 16'h0000, "busy");
      pollCount(0, d);
      chkRange("count", FRAME[i], d);
      cycles(3);
      chk("done irq", 16'h0001, 16'(irqSupervisory_q));
      rdChk(0, IRQ_STAT_OFS, 16'h0010, "done event");
    end
    regWrite(0, CFG_OFS, 16'h0001);
    regWrite(0, STAT_OFS, 16'h0000);
    cycles(2);
    regRead(1, COUNT_OFS, d);
    chkRange("idle copy", FRAME[2], d);
    rdChk(0, STAT_OFS, 16'h0007, "copy core0");
    rdChk(1, STAT_OFS, 16'h0037, "copy core1");
    regWrite(1, STAT_OFS, 16'h0010);
    rdChk(0, COUNT_OFS, 16'h0000, "busy core1");
    pollCount(1, d);
    chkRange("count core1", FRAME[1], d);
    regWrite(1, STAT_OFS, 16'h0000);
    cycles(100);
    regWrite(1, STAT_OFS, 16'h0030);
    cycles(WIN + 100);
    rdChk(0, COUNT_OFS, 16'h0000, "aborted");
    wrapUp();
  end
endmodule
